// >>> cd_decoder_config_regs.sv
// Decoder configuration bank: header reads, sync, DMA, audio link, refresh, command link
//
// The address-and-strobe port was left to the implementer.
`include "cd_decoder_consts.svh"
module cd_decoder_config_regs (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Register port
  input wire cd_decoder_pkg::reg_bus_t i_bus,
  output logic [7:0] o_read_data,
  // Sector header sources
  input wire logic i_decoder_interrupt,
  input wire cd_decoder_pkg::header_t i_raw_header,
  input wire logic [7:0] i_buffer_minute,
  input wire logic i_buffer_minute_valid,
  // Sync mark events
  input wire logic i_sync_inserted,
  input wire logic i_sync_detected,
  output logic o_sync_window_open,
  // Host FIFO
  input wire cd_decoder_pkg::fifo_status_t i_fifo,
  output logic o_dma_to_fifo_start,
  output logic o_dma_to_buffer_start,
  // Subcode
  output cd_decoder_pkg::corr_level_t o_subcode_correction_level,
  // Serial audio link
  input wire cd_decoder_pkg::audio_in_t i_audio,
  output logic [31:0] o_audio_word,
  output logic o_audio_left,
  output logic o_audio_valid,
  // Error pointer bytes
  input wire logic [7:0] i_error_pointer_byte,
  input wire logic i_error_pointer_valid,
  output logic [15:0] o_error_pointer_word,
  output logic o_error_pointer_ready,
  // Subheader check
  input wire cd_decoder_pkg::subheader_t i_subheader,
  output logic [3:0] o_buffered_header_flags,
  // DRAM refresh
  output logic o_refresh_request,
  // Command link
  input wire logic i_command_go,
  input wire logic [23:0] i_command_bytes,
  output cd_decoder_pkg::cmd_link_t o_command_link,
  output logic o_command_busy
);
  import cd_decoder_pkg::*;

  top_state_t st;
  top_state_t next_st;
  logic sample_edge; // Chosen bit clock edge seen this cycle
  logic word_edge; // Word clock changed level
  logic [31:0] next_shift; // Shift register after this cycle's bit
  logic [31:0] aligned_word; // Finished word, right aligned
  logic [5:0] half_count; // Strobe half period in clocks
  logic [1:0] byte_count; // Command length field
  logic div_tick; // Half period elapsed
  logic [9:0] refresh_limit; // Interval times four

  // Strobe timing source
  cd_strobe_divider u_divider (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_run(st.cmd_busy),
    .i_half_count(half_count),
    .o_tick(div_tick)
  );

  // Divider selection and command length decode
  always_comb begin
    byte_count = st.cmd_ctrl[4:3];
    refresh_limit = {2'h0, st.refresh_intvl} << `REFRESH_MULT;
    if (st.cmd_ctrl[`BIT_FAST_STROBE]) begin
      case (st.cmd_ctrl[7:6])
        2'h0: half_count = `HALF_DIV_48;
        2'h1: half_count = `HALF_DIV_16;
        2'h2: half_count = `HALF_DIV_8;
        default: half_count = `HALF_DIV_4;
      endcase
    end else begin
      case (st.cmd_ctrl[7:6])
        2'h0: half_count = `HALF_DIV_24;
        2'h1: half_count = `HALF_DIV_32;
        2'h2: half_count = `HALF_DIV_48;
        default: half_count = `HALF_DIV_64;
      endcase
    end
  end

  // Serial audio sampling helpers
  always_comb begin
    if (st.link_fmt[`BIT_EDGE_SELECT]) begin
      sample_edge = i_audio.bit_clock && !st.bclk_prev;
    end else begin
      sample_edge = !i_audio.bit_clock && st.bclk_prev;
    end
    word_edge = i_audio.word_clock != st.wclk_prev;
    if (st.link_fmt[`BIT_LSB_FIRST]) begin
      next_shift = {i_audio.data, st.shift[31:1]};
    end else begin
      next_shift = {st.shift[30:0], i_audio.data};
    end
    case (st.link_fmt[4:3])
      2'h0: aligned_word = st.link_fmt[`BIT_LSB_FIRST] ? {16'h0000, st.shift[31:16]}
                                                        : {16'h0000, st.shift[15:0]};
      2'h1: aligned_word = st.link_fmt[`BIT_LSB_FIRST] ? {8'h00, st.shift[31:8]}
                                                        : {8'h00, st.shift[23:0]};
      default: aligned_word = st.shift;
    endcase
  end

  // Next-state logic for the whole bank
  always_comb begin
    next_st = st;
    next_st.rd_data = 8'h00;
    next_st.audio_valid = 1'b0;
    next_st.ptr_valid = 1'b0;
    next_st.refresh_req = 1'b0;

    // writes land in control registers only
    if (i_bus.wr) begin
      case (i_bus.addr)
        `ADDR_CFG1: next_st.cfg1 = i_bus.wdata;
        `ADDR_LINK_FMT: next_st.link_fmt = i_bus.wdata;
        `ADDR_REFRESH: next_st.refresh_intvl = i_bus.wdata;
        `ADDR_CMD_CTRL: next_st.cmd_ctrl = i_bus.wdata;
        default: next_st.cmd_ctrl = st.cmd_ctrl;
      endcase
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        `ADDR_CFG1: next_st.rd_data = st.raw.second;
        `ADDR_LINK_FMT: next_st.rd_data = st.raw.block;
        `ADDR_REFRESH: next_st.rd_data = st.raw.mode;
        `ADDR_CMD_CTRL: next_st.rd_data = st.buf_valid ? st.buf_minute : 8'h00;
        default: next_st.rd_data = 8'h00;
      endcase
    end

    if (i_decoder_interrupt) begin
      next_st.raw = i_raw_header;
    end
    next_st.buf_valid = i_buffer_minute_valid;
    if (i_buffer_minute_valid) begin
      next_st.buf_minute = i_buffer_minute;
    end

    // count inserted marks; a detection restarts protection
    if (i_sync_detected) begin
      next_st.sync_count = 3'h0;
    end else if (i_sync_inserted && st.sync_count != 3'h7) begin
      next_st.sync_count = st.sync_count + 3'h1;
    end
    next_st.sync_window = st.cfg1[`BIT_WINDOW_FORCE] || (next_st.sync_count >= st.cfg1[6:4]);

    // DMA request policy for send and receive; weak form when bit low
    if (st.cfg1[`BIT_WEAK_DISABLE]) begin
      next_st.dma_to_fifo = i_fifo.send_cmd && i_fifo.empty_bytes >= `FIFO_THRESHOLD;
      // receive waits for eight bytes or final data
      next_st.dma_to_buffer = i_fifo.recv_cmd &&
        (i_fifo.filled_bytes >= `FIFO_THRESHOLD || i_fifo.final_data);
    end else begin
      next_st.dma_to_fifo = i_fifo.send_cmd && !i_fifo.fifo_full;
      next_st.dma_to_buffer = i_fifo.recv_cmd && i_fifo.filled_bytes != 6'h00;
    end

    // correction level decode; low bit clear means none
    case (st.cfg1[1:0])
      2'h1: next_st.corr_level = CORR_SINGLE;
      2'h3: next_st.corr_level = CORR_DOUBLE;
      default: next_st.corr_level = CORR_NONE;
    endcase

    // Serial audio deserializer
    next_st.bclk_prev = i_audio.bit_clock;
    next_st.wclk_prev = i_audio.word_clock;
    if (word_edge) begin
      // Half period ended: hand out the word gathered during it
      next_st.audio_word = aligned_word;
      next_st.audio_valid = 1'b1;
      // low word clock level marks left
      next_st.audio_left = st.link_fmt[`BIT_LEFT_POLARITY] ? !st.wclk_prev : !st.wclk_prev;
      next_st.shift = 32'h0000_0000;
    end else if (sample_edge) begin
      next_st.shift = next_shift;
    end

    if (i_error_pointer_valid) begin
      if (!st.ptr_have_first) begin
        next_st.ptr_first = i_error_pointer_byte;
        next_st.ptr_have_first = 1'b1;
      end else begin
        next_st.ptr_word = st.link_fmt[`BIT_PTR_LOW_FIRST] ?
          {i_error_pointer_byte, st.ptr_first} : {st.ptr_first, i_error_pointer_byte};
        next_st.ptr_valid = 1'b1;
        next_st.ptr_have_first = 1'b0;
      end
    end

    if (i_subheader.check) begin
      for (int i = 0; i < 4; i++) begin
        next_st.hdr_flags[i] = st.link_fmt[`BIT_SUBHDR_SELECT] ?
          (i_subheader.copy_a[8*i +: 8] != i_subheader.copy_b[8*i +: 8]) :
          (i_subheader.ptr_a[i] && i_subheader.ptr_b[i]);
      end
    end

    // refresh interval counter; zero interval stops refresh
    if (st.refresh_intvl == 8'h00) begin
      next_st.refresh_cnt = 10'h000;
    end else if (st.refresh_cnt >= refresh_limit - 10'h001) begin
      next_st.refresh_cnt = 10'h000;
      next_st.refresh_req = 1'b1;
    end else begin
      next_st.refresh_cnt = st.refresh_cnt + 10'h001;
    end

    // Command link sequencer
    case (st.cmd_state)
      CMD_IDLE: begin
        next_st.link = '0;
        if (i_command_go && byte_count != 2'h0) begin
          next_st.cmd_shift = i_command_bytes << (`BITS_PER_BYTE * (5'h03 - {3'h0, byte_count}));
          next_st.cmd_bits = `BITS_PER_BYTE * {3'h0, byte_count};
          next_st.link.data = next_st.cmd_shift[23];
          next_st.cmd_busy = 1'b1;
          next_st.cmd_state = CMD_SHIFT;
        end
      end
      CMD_SHIFT: begin
        if (div_tick) begin
          if (!st.link.strobe) begin
            next_st.link.strobe = 1'b1;
          end else begin
            next_st.link.strobe = 1'b0;
            next_st.cmd_shift = {st.cmd_shift[22:0], 1'b0};
            next_st.link.data = st.cmd_shift[22];
            next_st.cmd_bits = st.cmd_bits - 5'h01;
            if (st.cmd_bits == 5'h01) begin
              next_st.link.data = 1'b0;
              next_st.cmd_state = CMD_LATCH;
            end
          end
        end
      end
      CMD_LATCH: begin
        // Latch pulse lasts one half period unless disabled
        if (div_tick) begin
          if (!st.link.latch && !st.cmd_ctrl[`BIT_LATCH_DISABLE]) begin
            next_st.link.latch = 1'b1;
          end else begin
            next_st.link.latch = 1'b0;
            next_st.cmd_busy = 1'b0;
            next_st.cmd_state = CMD_IDLE;
          end
        end
      end
      default: begin
        next_st.link = '0;
        next_st.cmd_busy = 1'b0;
        next_st.cmd_state = CMD_IDLE;
      end
    endcase
  end

  // State register with documented reset values
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st <= '0;
      // Word clock idles high; matching it avoids a false word edge after reset
      st.wclk_prev <= 1'b1;
      st.cfg1 <= `CFG1_RST;
      st.link_fmt <= `LINK_FMT_RST;
      st.cmd_state <= CMD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign o_read_data = st.rd_data;
  assign o_sync_window_open = st.sync_window;
  assign o_dma_to_fifo_start = st.dma_to_fifo;
  assign o_dma_to_buffer_start = st.dma_to_buffer;
  assign o_subcode_correction_level = st.corr_level;
  assign o_audio_word = st.audio_word;
  assign o_audio_left = st.audio_left;
  assign o_audio_valid = st.audio_valid;
  assign o_error_pointer_word = st.ptr_word;
  assign o_error_pointer_ready = st.ptr_valid;
  assign o_buffered_header_flags = st.hdr_flags;
  assign o_refresh_request = st.refresh_req;
  assign o_command_link = st.link;
  assign o_command_busy = st.cmd_busy;

  // Checks
  link_reset_value_a: assert property (@(posedge i_core_clk)
    i_reset |=> st.link_fmt == `LINK_FMT_RST) else $error("link format reset wrong");
  raw_header_follow_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_decoder_interrupt ##1 (i_bus.rd && i_bus.addr == `ADDR_LINK_FMT)) |=>
    o_read_data == $past(i_raw_header.block, 2)) else $error("raw block not read back");
  window_force_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    st.cfg1[`BIT_WINDOW_FORCE] |=> o_sync_window_open) else $error("forced window closed");
  send_threshold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st.cfg1[`BIT_WEAK_DISABLE] && i_fifo.empty_bytes < `FIFO_THRESHOLD) |=>
    !o_dma_to_fifo_start) else $error("send DMA started below threshold");
  recv_weak_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!st.cfg1[`BIT_WEAK_DISABLE] && i_fifo.recv_cmd && i_fifo.filled_bytes != 6'h00) |=>
    o_dma_to_buffer_start) else $error("weak receive DMA not started");
  recv_strict_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st.cfg1[`BIT_WEAK_DISABLE] && i_fifo.filled_bytes < `FIFO_THRESHOLD && !i_fifo.final_data)
    |=> !o_dma_to_buffer_start) else $error("receive DMA started early");
  corr_level_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !st.cfg1[0] |=> o_subcode_correction_level == CORR_NONE) else $error("correction set");
  refresh_period_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_refresh_request && st.refresh_intvl == 8'h01 && !i_bus.wr) |=>
    (!o_refresh_request && !i_bus.wr) [*3] |=> o_refresh_request)
    else $error("refresh period wrong");
  latch_disable_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(o_command_link.latch) |-> !st.cmd_ctrl[`BIT_LATCH_DISABLE])
    else $error("latch pulse while disabled");
  zero_length_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_command_go && !o_command_busy && byte_count == 2'h0) |=> !o_command_busy)
    else $error("zero length command started");
  minute_invalid_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!st.buf_valid && i_bus.rd && i_bus.addr == `ADDR_CMD_CTRL) |=> o_read_data == 8'h00)
    else $error("minute read while invalid");

  // Main scenarios
  cmd_done_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(o_command_busy));
  audio_word_c: cover property (@(posedge i_core_clk) disable iff (i_reset) o_audio_valid);
  refresh_c: cover property (@(posedge i_core_clk) disable iff (i_reset) o_refresh_request);
endmodule : cd_decoder_config_regs

// >>> cd_decoder_consts.svh
// Register offsets, field positions, reset values and counts for the decoder config bank
`ifndef CD_DECODER_CONSTS_SVH
`define CD_DECODER_CONSTS_SVH
`define ADDR_CFG1 8'h00
`define ADDR_LINK_FMT 8'h02
`define ADDR_REFRESH 8'h03
`define ADDR_CMD_CTRL 8'h04
`define CFG1_RST 8'h20
`define LINK_FMT_RST 8'h28
`define BIT_WINDOW_FORCE 7
`define BIT_WEAK_DISABLE 3
`define BIT_PTR_LOW_FIRST 7
`define BIT_LEFT_POLARITY 6
`define BIT_EDGE_SELECT 5
`define BIT_LSB_FIRST 2
`define BIT_SUBHDR_SELECT 0
`define BIT_LATCH_DISABLE 5
`define BIT_FAST_STROBE 2
`define FIFO_THRESHOLD 6'h08
`define REFRESH_MULT 2
`define BITS_PER_BYTE 5'h08
`define HALF_DIV_24 6'h0C
`define HALF_DIV_32 6'h10
`define HALF_DIV_48 6'h18
`define HALF_DIV_64 6'h20
`define HALF_DIV_16 6'h08
`define HALF_DIV_8 6'h04
`define HALF_DIV_4 6'h02
`endif

// >>> cd_decoder_pkg.sv
// Types shared by the decoder configuration bank and its strobe divider
package cd_decoder_pkg;
  // Command link sequencer states, one-hot
  typedef enum logic [2:0] {CMD_IDLE = 3'h1, CMD_SHIFT = 3'h2, CMD_LATCH = 3'h4} cmd_state_t;
  // Subcode correction level as applied
  typedef enum logic [1:0] {CORR_NONE = 2'h0, CORR_SINGLE = 2'h1, CORR_DOUBLE = 2'h3} corr_level_t;
  // Plain register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_bus_t;
  // Raw header bytes from the signal processor
  typedef struct packed {
    logic [7:0] second;
    logic [7:0] block;
    logic [7:0] mode;
  } header_t;
  // Host FIFO state and active command kind
  typedef struct packed {
    logic send_cmd;
    logic recv_cmd;
    logic fifo_full;
    logic final_data;
    logic [5:0] empty_bytes;
    logic [5:0] filled_bytes;
  } fifo_status_t;
  // Serial audio link pins
  typedef struct packed {
    logic bit_clock;
    logic word_clock;
    logic data;
  } audio_in_t;
  // Two subheader copies and their error pointers
  typedef struct packed {
    logic [31:0] copy_a;
    logic [31:0] copy_b;
    logic [3:0] ptr_a;
    logic [3:0] ptr_b;
    logic check;
  } subheader_t;
  // Command link outputs
  typedef struct packed {
    logic strobe;
    logic data;
    logic latch;
  } cmd_link_t;
  // Divider state
  typedef struct packed {
    logic [5:0] count;
    logic tick;
  } div_state_t;
  // Whole state of the configuration bank
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] link_fmt;
    logic [7:0] refresh_intvl;
    logic [7:0] cmd_ctrl;
    logic [7:0] rd_data;
    header_t raw;
    logic [7:0] buf_minute;
    logic buf_valid;
    logic [2:0] sync_count;
    logic sync_window;
    logic dma_to_fifo;
    logic dma_to_buffer;
    corr_level_t corr_level;
    logic bclk_prev;
    logic wclk_prev;
    logic [31:0] shift;
    logic [31:0] audio_word;
    logic audio_left;
    logic audio_valid;
    logic [7:0] ptr_first;
    logic ptr_have_first;
    logic [15:0] ptr_word;
    logic ptr_valid;
    logic [3:0] hdr_flags;
    logic [9:0] refresh_cnt;
    logic refresh_req;
    cmd_state_t cmd_state;
    logic [23:0] cmd_shift;
    logic [4:0] cmd_bits;
    cmd_link_t link;
    logic cmd_busy;
  } top_state_t;
endpackage : cd_decoder_pkg

// >>> cd_strobe_divider.sv
// Crystal clock divider that ticks once per half period of the command strobe
`include "cd_decoder_consts.svh"
module cd_strobe_divider (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Control
  input wire logic i_run,
  input wire logic [5:0] i_half_count,
  // Half-period tick
  output logic o_tick
);
  import cd_decoder_pkg::*;

  div_state_t st;
  div_state_t next_st;

  // Count clocks; tick at the end of each half period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!i_run) begin
      // Idle keeps phase at zero so every frame starts alike
      next_st.count = 6'h00;
    end else if (st.count >= i_half_count - 6'h01) begin
      next_st.count = 6'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 6'h01;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

  tick_gap_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_tick && i_run && $stable(i_half_count) && i_half_count == `HALF_DIV_4) |=>
    !o_tick ##1 (o_tick || !i_run)) else $error("divider tick gap wrong");
endmodule : cd_strobe_divider

// >>> cd_dsp_link_model.sv
// Serial audio source standing in for the disc signal processor
module cd_dsp_link_model (
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_start,
  input wire logic [31:0] i_word,
  input wire logic [5:0] i_nbits,
  input wire logic i_lsb_first,
  input wire logic i_rise,
  // Link pins and completion
  output cd_decoder_pkg::audio_in_t o_audio,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import cd_decoder_pkg::*;
  logic bit_now; // Bit being sent
  // Idle: bit clock still, word clock high
  initial begin
    o_audio = 3'h2;
    o_done = 1'h0;
  end
  // One half word; data changes between the two bit clock edges
  always @(posedge i_core_clk) begin
    if (i_start) begin
      o_done <= 1'h0;
      o_audio.word_clock <= 1'h0;
      repeat (4) @(posedge i_core_clk);
      for (int k = 0; k < i_nbits; k++) begin
        bit_now = i_lsb_first ? i_word[k] : i_word[i_nbits - 1 - k];
        // Wrong level at the edge that must not sample, so a wrong edge shows up
        o_audio.data <= bit_now ^ !i_rise;
        repeat (3) @(posedge i_core_clk);
        o_audio.bit_clock <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        o_audio.data <= bit_now ^ i_rise;
        @(posedge i_core_clk);
        o_audio.bit_clock <= 1'h0;
        // Gap so the next bit never meets the sampling edge
        repeat (3) @(posedge i_core_clk);
      end
      // Released data line shows the inverse, not a stale bit
      o_audio.data <= ~o_audio.data;
      o_audio.word_clock <= 1'h1;
      repeat (4) @(posedge i_core_clk);
      o_done <= 1'h1;
    end
  end
endmodule : cd_dsp_link_model

// >>> test_cd_decoder_config_regs.sv
// Self-checking bench for the decoder configuration bank
module test_cd_decoder_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import cd_decoder_pkg::*;
  // Config row: written value, FIFO state, expected outputs
  typedef struct packed {
    logic [7:0] cfg;
    fifo_status_t fifo;
    logic [1:0] corr;
    logic tf;
    logic tb;
  } row_t;
  // FIFO nibble: send recv full final, then empty and filled counts
  row_t rows[7] = '{'{8'h20, {4'h8, 6'h02, 6'h00}, 2'h0, 1'h1, 1'h0},
    '{8'h29, {4'h8, 6'h07, 6'h00}, 2'h1, 1'h0, 1'h0},
    '{8'h2B, {4'h8, 6'h08, 6'h00}, 2'h3, 1'h1, 1'h0},
    '{8'h2A, {4'h4, 6'h00, 6'h07}, 2'h0, 1'h0, 1'h0},
    '{8'h2A, {4'h5, 6'h00, 6'h07}, 2'h0, 1'h0, 1'h1},
    '{8'h22, {4'h4, 6'h00, 6'h01}, 2'h0, 1'h0, 1'h1},
    '{8'h20, {4'hA, 6'h00, 6'h00}, 2'h0, 1'h0, 1'h0}};
  logic [7:0] addrs[5] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05};
  logic [7:0] rexp[5] = '{8'h12, 8'h34, 8'h56, 8'h59, 8'h00};
  logic [7:0] fmts[3] = '{8'h28, 8'h95, 8'h20};
  // normal divider settings used here keep the strobe under 1 MHz
  logic [7:0] ctls[7] = '{8'h48, 8'h90, 8'hC8, 8'h0C, 8'h5C, 8'h8C, 8'hEC};
  logic [5:0] halfs[7] = '{6'h10, 6'h18, 6'h20, 6'h18, 6'h08, 6'h04, 6'h02};
  // Stimulus and observed signals
  logic clk, rst, intr, mvalid, ins, det, pvalid, go, a_start, a_lsb, a_rise, a_done;
  logic win, to_fifo, to_buf, aleft, avalid, pready, refresh, busy, got_left;
  reg_bus_t bus;
  header_t hdr;
  fifo_status_t fifo;
  subheader_t sub;
  audio_in_t aud;
  corr_level_t corr;
  cmd_link_t link;
  logic [7:0] rdata, minute, pbyte, rv;
  logic [23:0] cbytes, got;
  logic [31:0] a_word, aword, got_word;
  logic [15:0] pword;
  logic [5:0] a_bits, nbits;
  logic [3:0] flags;
  int n, nb, fail_count, total_checks;
  cd_decoder_config_regs cd_decoder_config_regs_inst (
    .i_core_clk(clk), .i_reset(rst), .i_bus(bus), .o_read_data(rdata),
    .i_decoder_interrupt(intr), .i_raw_header(hdr), .i_buffer_minute(minute),
    .i_buffer_minute_valid(mvalid), .i_sync_inserted(ins), .i_sync_detected(det),
    .o_sync_window_open(win), .i_fifo(fifo), .o_dma_to_fifo_start(to_fifo),
    .o_dma_to_buffer_start(to_buf), .o_subcode_correction_level(corr),
    .i_audio(aud), .o_audio_word(aword), .o_audio_left(aleft), .o_audio_valid(avalid),
    .i_error_pointer_byte(pbyte), .i_error_pointer_valid(pvalid),
    .o_error_pointer_word(pword), .o_error_pointer_ready(pready),
    .i_subheader(sub), .o_buffered_header_flags(flags), .o_refresh_request(refresh),
    .i_command_go(go), .i_command_bytes(cbytes), .o_command_link(link),
    .o_command_busy(busy));
  cd_dsp_link_model cd_dsp_link_model_inst (
    .i_core_clk(clk), .i_start(a_start), .i_word(a_word), .i_nbits(a_bits),
    .i_lsb_first(a_lsb), .i_rise(a_rise), .o_audio(aud), .o_done(a_done));
  // 25 MHz clock
  always #20 clk = ~clk;
  // Keep the last finished audio word
  always @(posedge clk) begin
    if (avalid === 1'h1) begin
      got_word <= aword;
      got_left <= aleft;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
    bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : bus_write
  // Read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [7:0] v);
    bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    v = rdata;
  endtask : bus_read
  function automatic logic sig(input int s);
    case (s)
      0: return refresh;
      1: return link.strobe;
      2: return link.latch;
      3: return busy;
      default: return a_done;
    endcase
  endfunction : sig
  // Bounded wait; n counts the edges taken
  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(s) !== v && n < 3000);
    // A wait that runs out counts as a mismatch
    if (sig(s) !== v) fail_count++;
  endtask : wait_lvl
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // Watchdog, several times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    {clk, rst, intr, mvalid} = 4'h7;
    {ins, det, pvalid, go, a_start, a_lsb, a_rise} = '0;
    {bus, fifo, pbyte, a_word, a_bits} = '0;
    hdr = 24'h123456;
    minute = 8'h59;
    sub = '{32'h11223344, 32'h11228844, 4'hA, 4'hC, 1'h0};
    cbytes = 24'hC3A55A;
    fail_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    check(corr, CORR_NONE);
    check(win, 0);
    foreach (rows[i]) begin
      bus_write(8'h00, rows[i].cfg);
      fifo <= rows[i].fifo;
      repeat (2) @(posedge clk);
      check(corr, rows[i].corr);
      check({to_fifo, to_buf}, {rows[i].tf, rows[i].tb});
    end
    fifo <= '0;
    foreach (addrs[i]) begin
      bus_read(addrs[i], rv);
      check(rv, rexp[i]);
    end
    // Decoder idle from here: raw bytes frozen, minute invalid
    {intr, mvalid} <= 2'h0;
    hdr <= 24'hABCDEF;
    @(posedge clk);
    bus_read(8'h00, rv);
    check(rv, 8'h12);
    bus_read(8'h04, rv);
    check(rv, 8'h00);
    bus_write(8'h00, 8'h30);
    for (int k = 1; k <= 3; k++) begin
      ins <= 1'h1;
      @(posedge clk);
      ins <= 1'h0;
      repeat (2) @(posedge clk);
      check(win, k == 3);
    end
    det <= 1'h1;
    @(posedge clk);
    det <= 1'h0;
    repeat (2) @(posedge clk);
    check(win, 0);
    bus_write(8'h00, 8'hB0);
    @(posedge clk);
    check(win, 1);
    bus_write(8'h03, 8'h03);
    wait_lvl(0, 1, n);
    wait_lvl(0, 1, n);
    check(n, 12);
    bus_write(8'h03, 8'h01);
    wait_lvl(0, 1, n);
    wait_lvl(0, 1, n);
    check(n, 4);
    foreach (fmts[i]) begin
      // format rewritten only while decoder idle
      if (i > 0) bus_write(8'h02, fmts[i]);
      nbits = fmts[i][4] ? 6'h20 : (fmts[i][3] ? 6'h18 : 6'h10);
      {a_bits, a_lsb, a_rise, a_word, a_start} <=
        {nbits, fmts[i][2], fmts[i][5], 32'h9ABCDEF1, 1'h1};
      @(posedge clk);
      a_start <= 1'h0;
      wait_lvl(4, 1, n);
      check(got_word, 32'h9ABCDEF1 & ~(32'hFFFFFFFF << nbits));
      check(got_left, 1);
      {pvalid, pbyte} <= 9'h112;
      @(posedge clk);
      pbyte <= 8'h34;
      @(posedge clk);
      {pvalid, sub.check} <= 2'h1;
      @(posedge clk);
      sub.check <= 1'h0;
      check(pready, 1);
      check(pword, fmts[i][7] ? 16'h3412 : 16'h1234);
      @(posedge clk);
      check(flags, fmts[i][0] ? 4'h2 : 4'h8);
    end
    foreach (ctls[i]) begin
      bus_write(8'h04, ctls[i]);
      nb = 8 * ctls[i][4:3];
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      got = '0;
      for (int k = 0; k < nb; k++) begin
        wait_lvl(1, 1, n);
        got = {got[22:0], link.data};
        if (k < nb - 1) begin
          wait_lvl(1, 0, n);
          if (k == 0) check(n, halfs[i]);
        end
      end
      check(got, cbytes & ~(24'hFFFFFF << nb));
      if (!ctls[i][5]) begin
        wait_lvl(2, 1, n);
        wait_lvl(2, 0, n);
        check(n, halfs[i]);
      end
      wait_lvl(3, 0, n);
      check(n, ctls[i][5] ? 2 * halfs[i] : 1);
    end
    // Length code zero must be refused
    bus_write(8'h04, 8'h40);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (2) @(posedge clk);
    check(busy, 0);
    final_report();
  end
endmodule : test_cd_decoder_config_regs
